/* File: instruction_timing_flags_consts.vh */
// Constants for the instruction timing and flag unit.
// Definitions only.
`ifndef INSTRUCTION_TIMING_FLAGS_CONSTS_VH
`define INSTRUCTION_TIMING_FLAGS_CONSTS_VH

// Instruction class codes on i_op
`define OP_W 6
`define OP_NOP 6'h00
`define OP_ADD 6'h01
`define OP_ADC 6'h02
`define OP_SUB 6'h03
`define OP_SBC 6'h04
`define OP_DAA 6'h05
`define OP_AND 6'h06
`define OP_OR 6'h07
`define OP_XOR 6'h08
`define OP_CPL 6'h09
`define OP_INC 6'h0a
`define OP_DEC 6'h0b
`define OP_RR 6'h0c
`define OP_RL 6'h0d
`define OP_RRC 6'h0e
`define OP_RLC 6'h0f
`define OP_MOV 6'h10
`define OP_CLRB 6'h11
`define OP_SETB 6'h12
`define OP_JMP 6'h13
`define OP_SZ 6'h14
`define OP_SZB 6'h15
`define OP_SNZB 6'h16
`define OP_SIZ 6'h17
`define OP_SDZ 6'h18
`define OP_CALL 6'h19
`define OP_RET 6'h1a
`define OP_RETA 6'h1b
`define OP_RETI 6'h1c
`define OP_TABC 6'h1d
`define OP_TABL 6'h1e
`define OP_CLR 6'h1f
`define OP_SET 6'h20
`define OP_CLRWDT 6'h21
`define OP_WDT1 6'h22
`define OP_WDT2 6'h23
`define OP_SWAP 6'h24
`define OP_HALT 6'h25

// Timing
`define CYC_W 3
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_EXTRA 3'h1
`define SYSCLK_PER_CYC 5'h04
`define CNT_W 5
`define CNT_ONE 5'h01

// Datapath constants
`define BYTE_ZERO 8'h00
`define BYTE_ONES 8'hff
`define BYTE_ONE 8'h01
`define NIB_ONE 5'h01
`define NIB_LIMIT 5'h09
`define NIB_ADJ 5'h06
`define NIB_ZERO 5'h00

// Watchdog clock source select
`define WDT_SRC_W 2
`define WDT_SRC_OSC 2'h0
`define WDT_SRC_SYS4 2'h1
`define WDT_DIV_W 2
`define WDT_DIV_LAST 2'h3
`define WDT_DIV_ONE 2'h1

`endif

/* File: instruction_timing_flags.v */
// Instruction execution control: cycle timing, flags, table read, watchdog.
// Assumes operands stable from i_start to o_done, inputs on i_clk.
`timescale 1ns/10ps
`include "instruction_timing_flags_consts.vh"

// Operation
// - Return, jump, call: two cycles, stack action except jump
// - Current-page table read: low mem, high latch
// - Last-page table read: low mem, high latch
// - Writing pc low byte adds one cycle
// - Taken skip adds one cycle, else none
// - Memory inc/dec skips take both penalties
// - Accumulator inc/dec skips: skip penalty only
// - Pre-clears clear timeout/sleep flags only on clear
// - Option: one or two clear instructions
// - Watchdog clock source and enable options
// - Power-down: one cycle, sets sleep flags
// - Add/subtract update zero, carry, half, wrap
// - Decimal adjust to memory, carry only
// - Logic and complement: zero flag, one cycle
// - Rotates: plain none, through-carry carry only
// - Bit ops use bits 0..7, no flags
// - Add-with-carry register form into accumulator
// - Add-with-carry memory form into memory
// - Nibble swap to memory or accumulator, no flags
// - Bit test skips on matching condition
// - Subtract memory form stores difference
module instruction_timing_flags #(
    parameter DATA_W = 8
) (
    input wire i_clk,
    input wire i_srst,
    input wire i_start,
    input wire [`OP_W-1:0] i_op,
    input wire i_dest_mem,
    input wire i_use_imm,
    input wire [2:0] i_bit_sel,
    input wire i_dst_is_pcl,
    input wire [DATA_W-1:0] i_acc,
    input wire [DATA_W-1:0] i_mem,
    input wire [DATA_W-1:0] i_imm,
    input wire [2*DATA_W-1:0] i_rom_word,
    input wire i_two_clear_mode,
    input wire [`WDT_SRC_W-1:0] i_wdt_src,
    input wire i_wdt_enable,
    input wire i_wdt_osc_tick,
    input wire i_wdt_timeout,
    output wire o_busy,
    output reg o_done,
    output reg [DATA_W-1:0] o_result,
    output reg o_mem_we,
    output reg o_acc_we,
    output reg o_skip,
    output reg o_stack_push,
    output reg o_stack_pop,
    output reg o_rom_rd,
    output reg o_rom_last_page,
    output reg [DATA_W-1:0] o_table_high_latch,
    output reg [`CYC_W-1:0] o_cycles,
    output reg o_zero_flag,
    output reg o_carry_flag,
    output reg o_half_byte_carry,
    output reg o_signed_wrap_flag,
    output reg o_timeout_flag,
    output reg o_sleep_entered_flag,
    output reg o_sleep_req,
    output reg o_wdt_clear,
    output reg o_wdt_tick
);

    localparam ST_IDLE = 2'b01;
    localparam ST_EXEC = 2'b10;

    reg [1:0] state_r;
    reg [`CNT_W-1:0] clk_cnt_r;
    reg [`CYC_W-1:0] cyc_left_r;
    reg [DATA_W-1:0] res_r;
    reg mem_we_r;
    reg acc_we_r;
    reg is_table_r;
    reg pre1_r;
    reg pre2_r;
    reg [`WDT_DIV_W-1:0] div_r;

    reg [DATA_W-1:0] res_nxt;
    reg z_nxt;
    reg c_nxt;
    reg ac_nxt;
    reg ov_nxt;
    reg mem_we_nxt;
    reg acc_we_nxt;
    reg skip_nxt;
    reg [`CYC_W-1:0] base_nxt;
    reg [DATA_W-1:0] opnd;
    reg [DATA_W:0] sum;
    reg [4:0] half;
    reg sub_op;
    reg cin;
    reg [4:0] lo_adj;
    reg [4:0] hi_adj;
    reg [DATA_W-1:0] bit_mask;

    wire take = i_start & state_r[0];
    wire last_clk = (clk_cnt_r == `SYSCLK_PER_CYC);
    wire [DATA_W-1:0] opnd_inv = ~opnd;

    assign o_busy = state_r[1];

    // Shared adder; subtract adds the inverted operand
    always @* begin
        opnd = i_use_imm ? i_imm : i_mem;
        sub_op = (i_op == `OP_SUB) | (i_op == `OP_SBC);
        case (i_op)
            `OP_ADC: cin = o_carry_flag;
            `OP_SBC: cin = o_carry_flag;
            `OP_SUB: cin = 1'b1;
            default: cin = 1'b0;
        endcase
        sum = {1'b0, i_acc} + {1'b0, sub_op ? opnd_inv : opnd} + {8'h00, cin};
        half = {1'b0, i_acc[3:0]} + {1'b0, sub_op ? opnd_inv[3:0] : opnd[3:0]}
            + {4'h0, cin};
        bit_mask = `BYTE_ONE << i_bit_sel;
    end

    // Per-class result, flags and base cycles
    always @* begin
        res_nxt = i_mem;
        z_nxt = o_zero_flag;
        c_nxt = o_carry_flag;
        ac_nxt = o_half_byte_carry;
        ov_nxt = o_signed_wrap_flag;
        mem_we_nxt = 1'b0;
        acc_we_nxt = 1'b0;
        skip_nxt = 1'b0;
        base_nxt = `CYC_ONE;
        lo_adj = `NIB_ZERO;
        hi_adj = `NIB_ZERO;
        case (i_op)
            `OP_ADD, `OP_ADC, `OP_SUB, `OP_SBC: begin
                res_nxt = sum[DATA_W-1:0];
                z_nxt = (sum[DATA_W-1:0] == `BYTE_ZERO);
                c_nxt = sum[DATA_W];
                ac_nxt = half[4];
                ov_nxt = (i_acc[DATA_W-1] == (sub_op ? opnd_inv[DATA_W-1] :
                    opnd[DATA_W-1])) && (sum[DATA_W-1] != i_acc[DATA_W-1]);
                mem_we_nxt = i_dest_mem;
                acc_we_nxt = ~i_dest_mem;
            end
            `OP_DAA: begin
                // Low nibble first; its carry feeds the high nibble
                lo_adj = {1'b0, i_acc[3:0]};
                if ((lo_adj > `NIB_LIMIT) || o_half_byte_carry) begin
                    lo_adj = lo_adj + `NIB_ADJ;
                end
                hi_adj = {1'b0, i_acc[7:4]} + {4'h0, lo_adj[4]};
                if ((hi_adj > `NIB_LIMIT) || o_carry_flag) begin
                    hi_adj = hi_adj + `NIB_ADJ;
                    c_nxt = 1'b1;
                end
                res_nxt = {hi_adj[3:0], lo_adj[3:0]};
                mem_we_nxt = 1'b1;
            end
            `OP_AND, `OP_OR, `OP_XOR, `OP_CPL: begin
                case (i_op)
                    `OP_AND: res_nxt = i_acc & opnd;
                    `OP_OR: res_nxt = i_acc | opnd;
                    `OP_XOR: res_nxt = i_acc ^ opnd;
                    default: res_nxt = ~i_mem;
                endcase
                z_nxt = (res_nxt == `BYTE_ZERO);
                mem_we_nxt = i_dest_mem;
                acc_we_nxt = ~i_dest_mem;
            end
            `OP_INC, `OP_DEC, `OP_SIZ, `OP_SDZ: begin
                if ((i_op == `OP_INC) || (i_op == `OP_SIZ)) begin
                    res_nxt = i_mem + `BYTE_ONE;
                end else begin
                    res_nxt = i_mem - `BYTE_ONE;
                end
                if ((i_op == `OP_INC) || (i_op == `OP_DEC)) begin
                    z_nxt = (res_nxt == `BYTE_ZERO);
                end else begin
                    skip_nxt = (res_nxt == `BYTE_ZERO);
                end
                mem_we_nxt = i_dest_mem;
                acc_we_nxt = ~i_dest_mem;
            end
            `OP_RR, `OP_RL, `OP_RRC, `OP_RLC: begin
                case (i_op)
                    `OP_RR: res_nxt = {i_mem[0], i_mem[7:1]};
                    `OP_RL: res_nxt = {i_mem[6:0], i_mem[7]};
                    `OP_RRC: res_nxt = {o_carry_flag, i_mem[7:1]};
                    default: res_nxt = {i_mem[6:0], o_carry_flag};
                endcase
                if (i_op == `OP_RRC) begin
                    c_nxt = i_mem[0];
                end
                if (i_op == `OP_RLC) begin
                    c_nxt = i_mem[7];
                end
                mem_we_nxt = i_dest_mem;
                acc_we_nxt = ~i_dest_mem;
            end
            `OP_MOV: begin
                res_nxt = i_dest_mem ? i_acc : opnd;
                mem_we_nxt = i_dest_mem;
                acc_we_nxt = ~i_dest_mem;
            end
            `OP_CLRB: begin
                res_nxt = i_mem & ~bit_mask;
                mem_we_nxt = 1'b1;
            end
            `OP_SETB: begin
                res_nxt = i_mem | bit_mask;
                mem_we_nxt = 1'b1;
            end
            `OP_SZ: begin
                skip_nxt = (i_mem == `BYTE_ZERO);
                acc_we_nxt = ~i_dest_mem; // Accumulator form moves data
            end
            `OP_SZB: skip_nxt = ((i_mem & bit_mask) == `BYTE_ZERO);
            `OP_SNZB: skip_nxt = ((i_mem & bit_mask) != `BYTE_ZERO);
            `OP_JMP, `OP_CALL, `OP_RET, `OP_RETI: begin
                base_nxt = `CYC_TWO;
            end
            `OP_RETA: begin
                res_nxt = i_imm;
                acc_we_nxt = 1'b1;
                base_nxt = `CYC_TWO;
            end
            `OP_TABC, `OP_TABL: begin
                base_nxt = `CYC_TWO;
                mem_we_nxt = 1'b1;
            end
            `OP_CLR: begin
                res_nxt = `BYTE_ZERO;
                mem_we_nxt = 1'b1;
            end
            `OP_SET: begin
                res_nxt = `BYTE_ONES;
                mem_we_nxt = 1'b1;
            end
            `OP_SWAP: begin
                res_nxt = {i_mem[3:0], i_mem[7:4]};
                mem_we_nxt = i_dest_mem;
                acc_we_nxt = ~i_dest_mem;
            end
            default: res_nxt = i_mem; // NOP, watchdog, halt
        endcase
    end

    // Base plus pc low byte and skip penalties
    wire pcl_pen = mem_we_nxt & i_dst_is_pcl;
    wire [`CYC_W-1:0] total_cyc = base_nxt +
        (pcl_pen ? `CYC_EXTRA : {`CYC_W{1'b0}}) +
        (skip_nxt ? `CYC_EXTRA : {`CYC_W{1'b0}});

    // Two-clear mode needs both halves
    wire is_w1 = take & (i_op == `OP_WDT1);
    wire is_w2 = take & (i_op == `OP_WDT2);
    wire is_wc = take & (i_op == `OP_CLRWDT);
    wire wdt_clr_nxt = i_two_clear_mode ?
        ((is_w1 & pre2_r) | (is_w2 & pre1_r)) :
        is_wc;
    wire is_halt = take & (i_op == `OP_HALT);

    // Sequencer: four system clocks per instruction cycle
    always @(posedge i_clk) begin
        if (i_srst) begin
            state_r <= ST_IDLE;
            clk_cnt_r <= `CNT_ONE;
            cyc_left_r <= `CYC_ONE;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (i_start) begin
                        state_r <= ST_EXEC;
                        clk_cnt_r <= `CNT_ONE;
                        cyc_left_r <= total_cyc;
                    end
                end
                ST_EXEC: begin
                    if (last_clk) begin
                        clk_cnt_r <= `CNT_ONE;
                        cyc_left_r <= cyc_left_r - `CYC_ONE;
                        if (cyc_left_r == `CYC_ONE) begin
                            state_r <= ST_IDLE;
                            o_done <= 1'b1;
                        end
                    end else begin
                        clk_cnt_r <= clk_cnt_r + `CNT_ONE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Latch the result at issue; commit writes only with o_done
    always @(posedge i_clk) begin
        if (i_srst) begin
            res_r <= `BYTE_ZERO;
            mem_we_r <= 1'b0;
            acc_we_r <= 1'b0;
            is_table_r <= 1'b0;
            o_cycles <= {`CYC_W{1'b0}};
            o_skip <= 1'b0;
            o_result <= `BYTE_ZERO;
            o_mem_we <= 1'b0;
            o_acc_we <= 1'b0;
            o_table_high_latch <= `BYTE_ZERO;
        end else begin
            o_mem_we <= 1'b0;
            o_acc_we <= 1'b0;
            if (take) begin
                res_r <= res_nxt;
                mem_we_r <= mem_we_nxt;
                acc_we_r <= acc_we_nxt;
                is_table_r <= (i_op == `OP_TABC) | (i_op == `OP_TABL);
                o_cycles <= total_cyc;
                o_skip <= skip_nxt;
            end
            // ROM word must be valid by the final edge
            if (o_busy && last_clk && (cyc_left_r == `CYC_ONE)) begin
                o_mem_we <= mem_we_r;
                o_acc_we <= acc_we_r;
                o_result <= is_table_r ? i_rom_word[DATA_W-1:0] : res_r;
                if (is_table_r) begin
                    o_table_high_latch <= i_rom_word[2*DATA_W-1:DATA_W];
                end
            end
        end
    end

    // Issue-time strobes
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_stack_push <= 1'b0;
            o_stack_pop <= 1'b0;
            o_rom_rd <= 1'b0;
            o_rom_last_page <= 1'b0;
            o_sleep_req <= 1'b0;
            o_wdt_clear <= 1'b0;
        end else begin
            o_stack_push <= take & (i_op == `OP_CALL);
            o_stack_pop <= take & ((i_op == `OP_RET) |
                (i_op == `OP_RETA) | (i_op == `OP_RETI));
            o_rom_rd <= take & ((i_op == `OP_TABC) | (i_op == `OP_TABL));
            if (take) begin
                o_rom_last_page <= (i_op == `OP_TABL);
            end
            o_sleep_req <= is_halt;
            o_wdt_clear <= wdt_clr_nxt | is_halt;
        end
    end

    // Flags update at issue, hold through penalties
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_zero_flag <= 1'b0;
            o_carry_flag <= 1'b0;
            o_half_byte_carry <= 1'b0;
            o_signed_wrap_flag <= 1'b0;
        end else if (take) begin
            o_zero_flag <= z_nxt;
            o_carry_flag <= c_nxt;
            o_half_byte_carry <= ac_nxt;
            o_signed_wrap_flag <= ov_nxt;
        end
    end

    // Timeout and sleep flags; a timeout event wins over a clear
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_timeout_flag <= 1'b0;
            o_sleep_entered_flag <= 1'b0;
        end else begin
            if (i_wdt_timeout) begin
                o_timeout_flag <= 1'b1;
            end else if (is_halt | wdt_clr_nxt) begin
                o_timeout_flag <= 1'b0;
            end
            if (is_halt) begin
                o_sleep_entered_flag <= 1'b1;
            end else if (wdt_clr_nxt) begin
                o_sleep_entered_flag <= 1'b0;
            end
        end
    end

    // Pre-clear pairing restarts after a clear
    always @(posedge i_clk) begin
        if (i_srst) begin
            pre1_r <= 1'b0;
            pre2_r <= 1'b0;
        end else if (wdt_clr_nxt | is_halt) begin
            pre1_r <= 1'b0;
            pre2_r <= 1'b0;
        end else begin
            if (is_w1) begin
                pre1_r <= 1'b1;
            end
            if (is_w2) begin
                pre2_r <= 1'b1;
            end
        end
    end

    // Watchdog tick; divider free-runs
    always @(posedge i_clk) begin
        if (i_srst) begin
            div_r <= {`WDT_DIV_W{1'b0}};
            o_wdt_tick <= 1'b0;
        end else begin
            div_r <= div_r + `WDT_DIV_ONE;
            if (!i_wdt_enable) begin
                o_wdt_tick <= 1'b0;
            end else begin
                case (i_wdt_src)
                    `WDT_SRC_OSC: o_wdt_tick <= i_wdt_osc_tick;
                    `WDT_SRC_SYS4: o_wdt_tick <= (div_r == `WDT_DIV_LAST);
                    default: o_wdt_tick <= 1'b0;
                endcase
            end
        end
    end

endmodule

/* File: instruction_timing_flags_properties.sv */
// Concurrent checks for the instruction timing and flag unit.
// Bound to the unit; sees only its ports.
`timescale 1ns/10ps
`include "instruction_timing_flags_consts.vh"
module instruction_timing_flags_checker (
    input wire i_clk,
    input wire i_srst,
    input wire i_start,
    input wire [`OP_W-1:0] i_op,
    input wire i_dest_mem,
    input wire i_dst_is_pcl,
    input wire i_wdt_timeout,
    input wire o_busy,
    input wire o_done,
    input wire [`CYC_W-1:0] o_cycles,
    input wire o_rom_rd,
    input wire o_stack_push,
    input wire o_zero_flag,
    input wire o_carry_flag,
    input wire o_timeout_flag,
    input wire o_sleep_entered_flag,
    input wire o_sleep_req
);
    logic take;
    logic [4:0] cnt_r;
    assign take = i_start && !o_busy;
    // Edges since take; 16 clocks fit in five bits
    always @(posedge i_clk) begin
        if (i_srst || take) begin
            cnt_r <= 5'h00;
        end else if (o_busy) begin
            cnt_r <= cnt_r + 5'h01;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    property p_done_time;
        o_done |-> cnt_r == {o_cycles, 2'b00};
    endproperty
    a_done_time: assert property (p_done_time) else $error("done late");
    property p_two_cycle;
        take && !i_dst_is_pcl && i_op inside {`OP_JMP, `OP_CALL, `OP_RET,
            `OP_RETA, `OP_RETI, `OP_TABC, `OP_TABL} |=> o_cycles == 3'h2;
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("not two");
    property p_pcl_extra;
        take && i_op == `OP_ADD && i_dest_mem && i_dst_is_pcl
            |=> o_cycles == 3'h2;
    endproperty
    a_pcl_extra: assert property (p_pcl_extra) else $error("no extra");
    property p_logic_one;
        take && !i_dest_mem && i_op inside {`OP_AND, `OP_OR, `OP_XOR}
            |=> o_cycles == 3'h1;
    endproperty
    a_logic_one: assert property (p_logic_one) else $error("logic");
    property p_halt_flags;
        take && i_op == `OP_HALT && !i_wdt_timeout
            |=> o_sleep_entered_flag && !o_timeout_flag && o_sleep_req;
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("halt");
    property p_move_flags;
        take && i_op == `OP_MOV |=> $stable({o_zero_flag, o_carry_flag});
    endproperty
    a_move_flags: assert property (p_move_flags) else $error("move");
    property p_rotate_hold;
        take && i_op == `OP_RL |=> ##[0:3] $stable({o_zero_flag, o_carry_flag});
    endproperty
    a_rotate_hold: assert property (p_rotate_hold) else $error("rot");
    property p_table_fetch;
        take && i_op == `OP_TABC |=> o_rom_rd ##1 !o_rom_rd;
    endproperty
    a_table_fetch: assert property (p_table_fetch) else $error("fetch");
    property p_call_push;
        take && i_op == `OP_CALL |=> o_stack_push;
    endproperty
    a_call_push: assert property (p_call_push) else $error("push");
    property p_sleep_hold;
        take && !i_wdt_timeout && !(i_op inside {`OP_HALT, `OP_CLRWDT,
            `OP_WDT1, `OP_WDT2}) |=> $stable({o_timeout_flag,
            o_sleep_entered_flag});
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("wd flag");
endmodule

bind instruction_timing_flags instruction_timing_flags_checker u_chk (
    .i_clk, .i_srst, .i_start, .i_op, .i_dest_mem, .i_dst_is_pcl,
    .i_wdt_timeout, .o_busy, .o_done, .o_cycles, .o_rom_rd, .o_stack_push,
    .o_zero_flag, .o_carry_flag, .o_timeout_flag, .o_sleep_entered_flag,
    .o_sleep_req
);

/* File: test_instruction_timing_flags.sv */
// Self-checking bench for the instruction timing and flag unit.
// Assumes the unit and its checker are compiled first.
`timescale 1ns/10ps
`include "instruction_timing_flags_consts.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_instruction_timing_flags;
    logic i_clk = 0, i_srst = 1, i_start = 0, i_dest_mem = 0, i_use_imm = 0;
    logic i_dst_is_pcl = 0, i_two_clear_mode = 0, i_wdt_enable = 0;
    logic i_wdt_osc_tick = 0, i_wdt_timeout = 0;
    logic [5:0] i_op = 6'h00;
    logic [2:0] i_bit_sel = 3'h0;
    logic [7:0] i_acc = 8'h00, i_mem = 8'h00, i_imm = 8'h00;
    logic [15:0] i_rom_word = 16'h0000;
    logic [1:0] i_wdt_src = 2'h2;
    wire o_busy, o_done, o_mem_we, o_acc_we, o_skip, o_stack_push;
    wire o_stack_pop, o_rom_rd, o_rom_last_page, o_sleep_req, o_wdt_clear;
    wire o_wdt_tick, o_zero_flag, o_carry_flag, o_half_byte_carry;
    wire o_signed_wrap_flag, o_timeout_flag, o_sleep_entered_flag;
    wire [7:0] o_result, o_table_high_latch;
    wire [2:0] o_cycles;
    int n_mismatch = 0, tests_run = 0, n = 0;

    always #10 i_clk = ~i_clk;

    instruction_timing_flags u_instruction_timing_flags (.i_clk, .i_srst,
        .i_start, .i_op, .i_dest_mem, .i_use_imm, .i_bit_sel, .i_dst_is_pcl,
        .i_acc, .i_mem, .i_imm, .i_rom_word, .i_two_clear_mode, .i_wdt_src,
        .i_wdt_enable, .i_wdt_osc_tick, .i_wdt_timeout, .o_busy, .o_done,
        .o_result, .o_mem_we, .o_acc_we, .o_skip, .o_stack_push,
        .o_stack_pop, .o_rom_rd, .o_rom_last_page, .o_table_high_latch,
        .o_cycles, .o_zero_flag, .o_carry_flag, .o_half_byte_carry,
        .o_signed_wrap_flag, .o_timeout_flag, .o_sleep_entered_flag,
        .o_sleep_req, .o_wdt_clear, .o_wdt_tick);

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One instruction; n ends as clocks from take to done
    task automatic run(input logic [5:0] op, input logic dm,
                       input logic [7:0] a, input logic [7:0] m,
                       input logic pc_low_byte);
        int k;
        i_op = op;
        i_dest_mem = dm;
        i_acc = a;
        i_mem = m;
        i_dst_is_pcl = pc_low_byte;
        i_start = 1;
        @(posedge i_clk);
        #1 i_start = 0;
        n = 0;
        for (k = 0; k < 40 && o_done !== 1'b1; k++) begin
            @(posedge i_clk);
            #1 n++;
        end
        if (o_done !== 1'b1) begin
            n_mismatch++;
            end_sim;
        end
    endtask

    task automatic kick;
        i_wdt_timeout = 1;
        @(posedge i_clk);
        #1 i_wdt_timeout = 0;
        `CHK(o_timeout_flag, 1'b1)
    endtask

    task automatic t_arith;
        run(`OP_ADD, 0, 8'h7f, 8'h01, 0);
        `CHK({o_result, o_acc_we, o_mem_we, o_zero_flag, o_carry_flag, o_half_byte_carry, o_signed_wrap_flag}, {8'h80, 6'b100011})
        run(`OP_ADD, 0, 8'hff, 8'h01, 0);
        `CHK({o_result, o_zero_flag, o_carry_flag, o_half_byte_carry}, {8'h00, 3'b111})
        run(`OP_ADC, 0, 8'h10, 8'h20, 0);
        `CHK({o_result, o_acc_we, o_carry_flag, n[4:0]}, {8'h31, 2'b10, 5'd4})
        run(`OP_ADD, 0, 8'hff, 8'h01, 0);
        run(`OP_ADC, 1, 8'h05, 8'h05, 0);
        `CHK({o_result, o_mem_we, o_acc_we}, {8'h0b, 2'b10})
        run(`OP_SUB, 1, 8'h05, 8'h03, 0);
        `CHK({o_result, o_mem_we, o_carry_flag}, {8'h02, 2'b11})
        i_use_imm = 1;
        i_imm = 8'h05;
        run(`OP_SUB, 0, 8'h03, 8'h00, 0);
        i_use_imm = 0;
        `CHK({o_result, o_carry_flag, o_acc_we}, {8'hfe, 2'b01})
        run(`OP_ADD, 1, 8'h01, 8'h01, 1);
        `CHK(n, 8)
    endtask

    task automatic t_branch;
        logic [5:0] ops[5] = '{`OP_JMP, `OP_CALL, `OP_RET, `OP_RETA, `OP_RETI};
        foreach (ops[i]) begin
            run(ops[i], 0, 8'h00, 8'h00, 0);
            `CHK(n, 8)
        end
        i_imm = 8'h5a;
        run(`OP_RETA, 0, 8'h00, 8'h00, 0);
        `CHK({o_result, o_acc_we}, {8'h5a, 1'b1})
        i_rom_word = 16'hbeef;
        run(`OP_TABC, 1, 8'h00, 8'h00, 0);
        `CHK({o_result, o_table_high_latch, o_mem_we, o_rom_last_page, n[4:0]}, {16'hefbe, 2'b10, 5'd8})
        i_rom_word = 16'h1234;
        run(`OP_TABL, 1, 8'h00, 8'h00, 0);
        `CHK({o_result, o_table_high_latch, o_rom_last_page, n[4:0]}, {16'h3412, 1'b1, 5'd8})
        run(`OP_MOV, 1, 8'h10, 8'h00, 1);
        `CHK({o_result, n[4:0]}, {8'h10, 5'd8})
    endtask

    task automatic t_skip;
        run(`OP_SZ, 1, 8'h00, 8'h00, 0);
        `CHK({o_skip, n[4:0]}, {1'b1, 5'd8})
        run(`OP_SZ, 1, 8'h00, 8'h01, 0);
        `CHK({o_skip, n[4:0]}, {1'b0, 5'd4})
        i_bit_sel = 3'h7;
        run(`OP_SZB, 0, 8'h00, 8'h7f, 0);
        `CHK({o_skip, n[4:0]}, {1'b1, 5'd8})
        run(`OP_SETB, 1, 8'h00, 8'h00, 0);
        `CHK(o_result, 8'h80)
        i_bit_sel = 3'h0;
        run(`OP_SNZB, 0, 8'h00, 8'h01, 0);
        `CHK({o_skip, n[4:0]}, {1'b1, 5'd8})
        run(`OP_SNZB, 0, 8'h00, 8'hfe, 0);
        `CHK({o_skip, n[4:0]}, {1'b0, 5'd4})
        i_bit_sel = 3'h3;
        run(`OP_CLRB, 1, 8'h00, 8'hff, 0);
        `CHK(o_result, 8'hf7)
        run(`OP_SIZ, 1, 8'h00, 8'hff, 1);
        `CHK({o_result, o_mem_we, o_skip, n[4:0]}, {8'h00, 2'b11, 5'd12})
        run(`OP_SIZ, 0, 8'h00, 8'hff, 0);
        `CHK({o_acc_we, o_mem_we, o_skip, n[4:0]}, {3'b101, 5'd8})
        run(`OP_SDZ, 0, 8'h00, 8'h02, 0);
        `CHK({o_result, o_skip, n[4:0]}, {8'h01, 1'b0, 5'd4})
    endtask

    task automatic t_flags;
        run(`OP_ADD, 0, 8'h00, 8'h00, 0);
        run(`OP_DAA, 1, 8'h3a, 8'h00, 0);
        `CHK({o_result, o_mem_we, o_zero_flag, o_carry_flag}, {8'h40, 3'b110})
        run(`OP_DAA, 1, 8'h9a, 8'h00, 0);
        `CHK({o_result, o_carry_flag}, {8'h00, 1'b1})
        run(`OP_ADD, 0, 8'hff, 8'h01, 0);
        run(`OP_OR, 0, 8'h00, 8'h01, 0);
        `CHK({o_result, o_zero_flag, o_carry_flag, o_half_byte_carry, o_signed_wrap_flag, n[4:0]}, {8'h01, 4'b0110, 5'd4})
        run(`OP_XOR, 0, 8'hff, 8'hff, 0);
        `CHK({o_result, o_zero_flag, o_carry_flag}, {8'h00, 2'b11})
        run(`OP_CPL, 0, 8'h00, 8'h0f, 0);
        `CHK({o_result, o_zero_flag, o_carry_flag, n[4:0]}, {8'hf0, 2'b01, 5'd4})
        run(`OP_RL, 0, 8'h00, 8'h81, 0);
        `CHK({o_result, o_zero_flag, o_carry_flag}, {8'h03, 2'b01})
        run(`OP_RRC, 0, 8'h00, 8'h02, 0);
        `CHK({o_result, o_zero_flag, o_carry_flag}, {8'h81, 2'b00})
        run(`OP_RLC, 0, 8'h00, 8'h80, 0);
        `CHK({o_result, o_zero_flag, o_carry_flag}, {8'h00, 2'b01})
        run(`OP_SWAP, 0, 8'h00, 8'h12, 0);
        `CHK({o_result, o_acc_we, o_mem_we, o_zero_flag, o_carry_flag, o_half_byte_carry, n[4:0]}, {8'h21, 5'b10011, 5'd4})
    endtask

    task automatic t_wdog;
        run(`OP_HALT, 0, 8'h00, 8'h00, 0);
        `CHK({o_sleep_entered_flag, o_timeout_flag, n[4:0]}, {2'b10, 5'd4})
        kick;
        run(`OP_WDT1, 0, 8'h00, 8'h00, 0);
        `CHK({o_timeout_flag, o_sleep_entered_flag}, 2'b11)
        run(`OP_CLRWDT, 0, 8'h00, 8'h00, 0);
        `CHK({o_timeout_flag, o_sleep_entered_flag}, 2'b00)
        i_two_clear_mode = 1;
        run(`OP_HALT, 0, 8'h00, 8'h00, 0);
        kick;
        run(`OP_CLRWDT, 0, 8'h00, 8'h00, 0);
        `CHK({o_timeout_flag, o_sleep_entered_flag}, 2'b11)
        run(`OP_WDT1, 0, 8'h00, 8'h00, 0);
        run(`OP_WDT1, 0, 8'h00, 8'h00, 0);
        `CHK({o_timeout_flag, o_sleep_entered_flag}, 2'b11)
        run(`OP_WDT2, 0, 8'h00, 8'h00, 0);
        `CHK({o_timeout_flag, o_sleep_entered_flag}, 2'b00)
    endtask

    // Ticks in 40 clocks per setting
    task automatic win(input logic [1:0] s, input logic e, input logic ot,
                       input int exp);
        int cnt, k;
        cnt = 0;
        i_wdt_src = s;
        i_wdt_enable = e;
        repeat (4) @(posedge i_clk);
        #1;
        for (k = 0; k < 40; k++) begin
            i_wdt_osc_tick = ot && (k % 8 == 0);
            @(posedge i_clk);
            #1 cnt += (o_wdt_tick === 1'b1);
        end
        i_wdt_osc_tick = 0;
        `CHK(cnt, exp)
    endtask

    // Reset, then scenarios
    initial begin
        repeat (10) @(posedge i_clk);
        #1 i_srst = 0;
        `CHK({o_busy, o_done, o_zero_flag, o_timeout_flag}, 4'h0)
        t_arith;
        t_branch;
        t_skip;
        t_flags;
        t_wdog;
        win(2'h1, 1'b1, 1'b0, 10);
        win(2'h0, 1'b1, 1'b1, 5);
        win(2'h2, 1'b1, 1'b1, 0);
        win(2'h1, 1'b0, 1'b0, 0);
        end_sim;
    end
endmodule
